// ### rtl/sebl_pkg.sv
// Purpose: constants and types for the serial eeprom coefficient boot loader
// Assumes: 20 MHz hclk, AHB-Lite register access, one word per register
// Notes: register byte address is four times the register index
package sebl_pkg;

  // --------------------------------------------------------------------
  // register indices
  // --------------------------------------------------------------------
  localparam logic [7:0] IDX_CLK_SEL = 8'h55;
  localparam logic [7:0] IDX_CTRL = 8'h56;
  localparam logic [7:0] IDX_OPCODE = 8'h57;
  localparam logic [7:0] IDX_ADDR_HI = 8'h58;
  localparam logic [7:0] IDX_ADDR_MID = 8'h59;
  localparam logic [7:0] IDX_ADDR_LO = 8'h5a;
  localparam logic [7:0] IDX_RESULT = 8'h5b;
  localparam logic [7:0] IDX_BQ_CTRL = 8'h5c;
  localparam logic [7:0] IDX_IRQ_STS = 8'h70;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h71;

  // --------------------------------------------------------------------
  // field positions and reset values
  // --------------------------------------------------------------------
  localparam int CTRL_SRC = 0;
  localparam int CTRL_LSB = 1;
  localparam int CTRL_POL = 2;
  localparam int CTRL_RATE = 3;
  localparam int CTRL_WIDE = 5;
  localparam int RES_DONE = 0;
  localparam int RES_CRC = 1;
  localparam int BQ_FIRST = 0;
  localparam logic [7:0] RST_OPCODE = 8'h03;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // --------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------
  localparam int SYS_CLK_HZ = 20_000_000;
  localparam int SCK_R0_HZ = 1_250_000;
  localparam int SCK_R1_HZ = 2_500_000;
  localparam int SCK_R2_HZ = 5_000_000;
  localparam int SCK_R3_HZ = 10_000_000;
  localparam logic [3:0] HALF_R0 = 4'(SYS_CLK_HZ / (2 * SCK_R0_HZ));
  localparam logic [3:0] HALF_R1 = 4'(SYS_CLK_HZ / (2 * SCK_R1_HZ));
  localparam logic [3:0] HALF_R2 = 4'(SYS_CLK_HZ / (2 * SCK_R2_HZ));
  localparam logic [3:0] HALF_R3 = 4'(SYS_CLK_HZ / (2 * SCK_R3_HZ));

  // --------------------------------------------------------------------
  // frame layout
  // --------------------------------------------------------------------
  localparam logic [5:0] HDR_BITS_WIDE = 6'd32;
  localparam logic [5:0] HDR_BITS_NARROW = 6'd24;
  localparam logic [5:0] DATA_BYTES = 6'd40;
  localparam logic [8:0] TAIL_BITS = 9'd336;
  localparam logic [4:0] BQ_BYTES = 5'd20;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h1021;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_XFER = 4'b0010,
    ST_TAIL = 4'b0100,
    ST_END = 4'b1000
  } sebl_state_t;

endpackage

// ### rtl/sebl_sck_tick.sv
// Purpose: half-period strobe for the serial clock
// Assumes: rate code 0..3 from the loader, constant while run is high
// Notes: counter restarts whenever run drops
module sebl_sck_tick (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic run,
  input wire logic [1:0] rate,
  // strobe
  output logic tick
);

  logic [3:0] cnt_reg;
  logic [3:0] half_w;

  assign half_w = (rate == 2'd0) ? sebl_pkg::HALF_R0 :
                  (rate == 2'd1) ? sebl_pkg::HALF_R1 :
                  (rate == 2'd2) ? sebl_pkg::HALF_R2 : sebl_pkg::HALF_R3;
  assign tick = run && (cnt_reg == half_w - 4'h1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= 4'h0;
    end else if (!run || tick) begin
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end

  a_slow_spacing: assert property (@(posedge hclk) disable iff (!hresetn)
    (run && tick && rate == 2'd0) |=> (!tick) [*7])
    else $error("slowest clock half period too short");

endmodule

// ### rtl/sebl_crc16.sv
// Purpose: byte-wide crc over loaded coefficient bytes
// Assumes: one byte per enable
// Notes: msb-first polynomial update
module sebl_crc16 (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic clear,
  input wire logic en,
  input wire logic [7:0] din,
  // result
  output logic [15:0] crc
);

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      if (r[15] ^ d[i]) begin
        r = {r[14:0], 1'b0} ^ sebl_pkg::CRC_POLY;
      end else begin
        r = {r[14:0], 1'b0};
      end
    end
    return r;
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crc <= sebl_pkg::CRC_INIT;
    end else if (clear) begin
      crc <= sebl_pkg::CRC_INIT;
    end else if (en) begin
      crc <= crc_byte(crc, din);
    end
  end

endmodule

// ### rtl/sebl_boot_loader.sv
// Purpose: spi master that boot-loads coefficients from a serial eeprom
// Assumes: single-word AHB-Lite accesses with no overlapping data phase
// Notes: serial clock idles low; miso is resynchronised before use
module sebl_boot_loader (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // serial eeprom
  output logic sck,
  output logic cs_n,
  output logic mosi,
  input wire logic miso,
  // coefficient stream
  output logic coef_src_eeprom,
  output logic [7:0] coef_data,
  output logic coef_valid,
  output logic coef_first,
  output logic biquad_first_coef_flag,
  output logic busy,
  // interrupt
  output logic irq
);

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [3:0] clk_sel_reg;
  logic [5:0] ctrl_reg;
  logic [7:0] opcode_reg;
  logic [7:0] addr_hi_reg;
  logic [7:0] addr_mid_reg;
  logic [7:0] addr_lo_reg;
  logic bq_reg;
  logic done_reg;
  logic crc_err_reg;
  logic [1:0] irq_sts_reg;
  logic [1:0] irq_mask_reg;
  logic ap_valid_reg;
  logic ap_write_reg;
  logic [7:0] ap_idx_reg;
  logic [31:0] hrdata_reg;

  // engine state
  sebl_pkg::sebl_state_t state_reg;
  logic sck_reg;
  logic cs_n_reg;
  logic mosi_reg;
  logic [31:0] hdr_reg;
  logic [5:0] hdr_bits_reg;
  logic pol_q;
  logic lsb_q;
  logic [1:0] rate_q;
  logic [8:0] bit_cnt_reg;
  logic [7:0] rx_reg;
  logic [5:0] byte_idx_reg;
  logic [4:0] bq_cnt_reg;
  logic [15:0] crc_rx_reg;
  logic [7:0] coef_data_reg;
  logic coef_valid_reg;
  logic coef_first_reg;
  logic miso_s1;
  logic miso_s2;
  logic cap_p1_reg;
  logic cap_p2_reg;
  logic end_p1_reg;
  logic end_p2_reg;

  function automatic logic [7:0] rev8(input logic [7:0] d);
    return {d[0], d[1], d[2], d[3], d[4], d[5], d[6], d[7]};
  endfunction

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  logic take_w;
  logic addr_ok_w;
  logic [7:0] idx_w;
  logic [7:0] rd_mux_w;
  logic wr_en_w;
  logic [7:0] wdat_w;
  logic wr_ctrl_w;
  logic w1c_w;

  assign idx_w = haddr[9:2];
  assign addr_ok_w = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);
  assign take_w = hsel && hready && htrans[1];
  assign wr_en_w = ap_valid_reg && ap_write_reg;
  assign wdat_w = hwdata[7:0];
  assign wr_ctrl_w = wr_en_w && (ap_idx_reg == sebl_pkg::IDX_CTRL);
  assign w1c_w = wr_en_w && (ap_idx_reg == sebl_pkg::IDX_IRQ_STS);

  assign rd_mux_w = !addr_ok_w ? 8'h00 :
    (idx_w == sebl_pkg::IDX_CLK_SEL) ? {4'h0, clk_sel_reg} :
    (idx_w == sebl_pkg::IDX_CTRL) ? {2'h0, ctrl_reg} :
    (idx_w == sebl_pkg::IDX_OPCODE) ? opcode_reg :
    (idx_w == sebl_pkg::IDX_ADDR_HI) ? addr_hi_reg :
    (idx_w == sebl_pkg::IDX_ADDR_MID) ? addr_mid_reg :
    (idx_w == sebl_pkg::IDX_ADDR_LO) ? addr_lo_reg :
    (idx_w == sebl_pkg::IDX_RESULT) ? {6'h0, crc_err_reg, done_reg} :
    (idx_w == sebl_pkg::IDX_BQ_CTRL) ? {7'h0, bq_reg} :
    (idx_w == sebl_pkg::IDX_IRQ_STS) ? {6'h0, irq_sts_reg} :
    (idx_w == sebl_pkg::IDX_IRQ_MASK) ? {6'h0, irq_mask_reg} : 8'h00;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid_reg <= 1'b0;
      ap_write_reg <= 1'b0;
      ap_idx_reg <= 8'h00;
      hrdata_reg <= 32'h0;
    end else begin
      ap_valid_reg <= take_w && addr_ok_w;
      ap_write_reg <= hwrite;
      ap_idx_reg <= idx_w;
      if (take_w && !hwrite) begin
        hrdata_reg <= {24'h0, rd_mux_w};
      end
    end
  end

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_sel_reg <= sebl_pkg::RST_ZERO[3:0];
      ctrl_reg <= sebl_pkg::RST_ZERO[5:0];
      opcode_reg <= sebl_pkg::RST_OPCODE;
      addr_hi_reg <= sebl_pkg::RST_ZERO;
      addr_mid_reg <= sebl_pkg::RST_ZERO;
      addr_lo_reg <= sebl_pkg::RST_ZERO;
      bq_reg <= 1'b0;
      irq_mask_reg <= 2'h0;
    end else if (wr_en_w) begin
      case (ap_idx_reg)
        sebl_pkg::IDX_CLK_SEL: clk_sel_reg <= wdat_w[3:0];
        sebl_pkg::IDX_CTRL: ctrl_reg <= wdat_w[5:0];
        sebl_pkg::IDX_OPCODE: opcode_reg <= wdat_w;
        sebl_pkg::IDX_ADDR_HI: addr_hi_reg <= wdat_w;
        sebl_pkg::IDX_ADDR_MID: addr_mid_reg <= wdat_w;
        sebl_pkg::IDX_ADDR_LO: addr_lo_reg <= wdat_w;
        sebl_pkg::IDX_BQ_CTRL: bq_reg <= wdat_w[sebl_pkg::BQ_FIRST];
        sebl_pkg::IDX_IRQ_MASK: irq_mask_reg <= wdat_w[1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // frame setup
  // ----------------------------------------------------------------------
  logic start_w;
  logic wide_w;
  logic lsb_w;
  logic [1:0] eff_rate_w;
  logic [31:0] hdr_next_w;
  logic [7:0] op_w;
  logic [7:0] hi_w;
  logic [7:0] mid_w;
  logic [7:0] lo_w;

  // a load starts only on a 0 to 1 write of the source bit, never mid-frame
  assign start_w = wr_ctrl_w && wdat_w[sebl_pkg::CTRL_SRC] && !ctrl_reg[sebl_pkg::CTRL_SRC]
                   && (state_reg == sebl_pkg::ST_IDLE);
  assign wide_w = wdat_w[sebl_pkg::CTRL_WIDE];
  assign lsb_w = wdat_w[sebl_pkg::CTRL_LSB];
  // nonzero clock select bits 1:0 override the control rate field
  assign eff_rate_w = (clk_sel_reg[1:0] != 2'h0) ? clk_sel_reg[1:0] :
                      wdat_w[sebl_pkg::CTRL_RATE +: 2];
  assign op_w = lsb_w ? rev8(opcode_reg) : opcode_reg;
  assign hi_w = lsb_w ? rev8(addr_hi_reg) : addr_hi_reg;
  assign mid_w = lsb_w ? rev8(addr_mid_reg) : addr_mid_reg;
  assign lo_w = lsb_w ? rev8(addr_lo_reg) : addr_lo_reg;
  assign hdr_next_w = wide_w ? {op_w, hi_w, mid_w, lo_w} : {op_w, mid_w, lo_w, 8'h00};

  // ----------------------------------------------------------------------
  // serial engine
  // ----------------------------------------------------------------------
  logic tick;
  logic run_w;
  logic lead_w;
  logic drive_w;
  logic sample_w;
  logic in_data_w;
  logic last_w;
  logic byte_done_w;
  logic is_coef_w;
  logic [7:0] rx_byte_w;
  logic [15:0] crc_val;
  logic crc_mis_w;
  logic finish_w;

  assign run_w = (state_reg != sebl_pkg::ST_IDLE);
  assign lead_w = !sck_reg;
  // edge select 0 moves data on the rising edge, 1 on the falling edge
  assign drive_w = tick && (state_reg == sebl_pkg::ST_XFER) && (lead_w != pol_q);
  assign sample_w = tick && (state_reg == sebl_pkg::ST_XFER) && (lead_w == pol_q);
  assign in_data_w = bit_cnt_reg >= {3'h0, hdr_bits_reg};
  assign last_w = bit_cnt_reg == ({3'h0, hdr_bits_reg} + sebl_pkg::TAIL_BITS - 9'd1);
  // capture trails the sampling edge by the synchroniser depth
  assign byte_done_w = cap_p2_reg && end_p2_reg;
  assign is_coef_w = byte_idx_reg < sebl_pkg::DATA_BYTES;
  assign rx_byte_w = lsb_q ? {miso_s2, rx_reg[7:1]} : {rx_reg[6:0], miso_s2};
  assign crc_mis_w = crc_val != crc_rx_reg;
  assign finish_w = tick && (state_reg == sebl_pkg::ST_TAIL) && !cap_p1_reg && !cap_p2_reg;

  sebl_sck_tick u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(run_w),
    .rate(rate_q),
    .tick(tick)
  );

  sebl_crc16 u_crc (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(start_w),
    .en(byte_done_w && is_coef_w),
    .din(rx_byte_w),
    .crc(crc_val)
  );

  // first flop of the miso synchroniser feeds only the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      miso_s1 <= 1'b0;
      miso_s2 <= 1'b0;
    end else begin
      miso_s1 <= miso;
      miso_s2 <= miso_s1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= sebl_pkg::ST_IDLE;
      sck_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      mosi_reg <= 1'b0;
      hdr_reg <= 32'h0;
      hdr_bits_reg <= sebl_pkg::HDR_BITS_NARROW;
      pol_q <= 1'b0;
      lsb_q <= 1'b0;
      rate_q <= 2'h0;
      bit_cnt_reg <= 9'h0;
    end else begin
      case (state_reg)
        sebl_pkg::ST_IDLE: begin
          if (start_w) begin
            state_reg <= sebl_pkg::ST_XFER;
            cs_n_reg <= 1'b0;
            pol_q <= wdat_w[sebl_pkg::CTRL_POL];
            lsb_q <= lsb_w;
            rate_q <= eff_rate_w;
            bit_cnt_reg <= 9'h0;
            hdr_bits_reg <= wide_w ? sebl_pkg::HDR_BITS_WIDE : sebl_pkg::HDR_BITS_NARROW;
            if (wdat_w[sebl_pkg::CTRL_POL]) begin
              // falling-edge mode must present the first opcode bit before the first rise
              mosi_reg <= hdr_next_w[31];
              hdr_reg <= {hdr_next_w[30:0], 1'b0};
            end else begin
              hdr_reg <= hdr_next_w;
            end
          end
        end
        sebl_pkg::ST_XFER: begin
          if (tick) begin
            sck_reg <= !sck_reg;
          end
          if (drive_w) begin
            mosi_reg <= hdr_reg[31];
            hdr_reg <= {hdr_reg[30:0], 1'b0};
          end
          if (sample_w) begin
            bit_cnt_reg <= bit_cnt_reg + 9'd1;
            if (last_w) begin
              state_reg <= sebl_pkg::ST_TAIL;
            end
          end
        end
        sebl_pkg::ST_TAIL: begin
          if (tick) begin
            sck_reg <= 1'b0;
          end
          // select stays low until the last received byte has drained
          if (finish_w) begin
            cs_n_reg <= 1'b1;
            state_reg <= sebl_pkg::ST_END;
          end
        end
        sebl_pkg::ST_END: begin
          // one half period deselected before another frame may begin
          if (tick) begin
            state_reg <= sebl_pkg::ST_IDLE;
          end
        end
        default: state_reg <= sebl_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // receive path
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_reg <= 8'h00;
      byte_idx_reg <= 6'h0;
      bq_cnt_reg <= 5'h0;
      crc_rx_reg <= 16'h0;
      coef_data_reg <= 8'h00;
      coef_valid_reg <= 1'b0;
      coef_first_reg <= 1'b0;
      cap_p1_reg <= 1'b0;
      cap_p2_reg <= 1'b0;
      end_p1_reg <= 1'b0;
      end_p2_reg <= 1'b0;
    end else begin
      coef_valid_reg <= 1'b0;
      // miso reaches miso_s2 two clocks late; sampling it then keeps 5 and 10 MHz usable
      cap_p1_reg <= sample_w && in_data_w;
      cap_p2_reg <= cap_p1_reg;
      end_p1_reg <= (bit_cnt_reg[2:0] == 3'h7);
      end_p2_reg <= end_p1_reg;
      if (start_w) begin
        byte_idx_reg <= 6'h0;
        bq_cnt_reg <= 5'h0;
        crc_rx_reg <= 16'h0;
      end
      if (cap_p2_reg) begin
        rx_reg <= rx_byte_w;
      end
      if (byte_done_w) begin
        byte_idx_reg <= byte_idx_reg + 6'd1;
        if (is_coef_w) begin
          coef_data_reg <= rx_byte_w;
          coef_valid_reg <= 1'b1;
          coef_first_reg <= (bq_cnt_reg == 5'h0);
          bq_cnt_reg <= (bq_cnt_reg == sebl_pkg::BQ_BYTES - 5'd1) ? 5'h0 : bq_cnt_reg + 5'd1;
        end else begin
          crc_rx_reg <= {crc_rx_reg[7:0], rx_byte_w};
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // status and interrupt
  // ----------------------------------------------------------------------
  logic [1:0] ev_w;

  assign ev_w = {finish_w && crc_mis_w, finish_w};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_reg <= 1'b0;
      crc_err_reg <= 1'b0;
      irq_sts_reg <= 2'h0;
    end else begin
      if (start_w) begin
        done_reg <= 1'b0;
        crc_err_reg <= 1'b0;
      end else if (finish_w) begin
        done_reg <= 1'b1;
        crc_err_reg <= crc_mis_w;
      end
      // a new event wins over a same-cycle clear
      irq_sts_reg <= (irq_sts_reg & ~(w1c_w ? wdat_w[1:0] : 2'h0)) | ev_w;
    end
  end

  assign irq = |(irq_sts_reg & irq_mask_reg);
  assign sck = sck_reg;
  assign cs_n = cs_n_reg;
  assign mosi = mosi_reg;
  assign coef_src_eeprom = ctrl_reg[sebl_pkg::CTRL_SRC];
  assign coef_data = coef_data_reg;
  assign coef_valid = coef_valid_reg;
  assign coef_first = coef_first_reg;
  assign biquad_first_coef_flag = bq_reg;
  assign busy = run_w;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_rise_change: assert property (@(posedge hclk) disable iff (!hresetn)
    (!pol_q && !cs_n_reg && $changed(mosi_reg)) |-> $rose(sck_reg))
    else $error("data moved off the rising edge");

  a_fall_change: assert property (@(posedge hclk) disable iff (!hresetn)
    (pol_q && !cs_n_reg && $changed(mosi_reg)) |-> ($fell(sck_reg) || $fell(cs_n_reg)))
    else $error("data moved off the falling edge");

  a_opcode_lead: assert property (@(posedge hclk) disable iff (!hresetn)
    ($fell(cs_n_reg) && !pol_q) |-> hdr_reg[31:24] == (lsb_q ? rev8(opcode_reg) : opcode_reg))
    else $error("frame does not open with the read opcode");

  a_addr_width: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(cs_n_reg) |-> hdr_bits_reg == (ctrl_reg[sebl_pkg::CTRL_WIDE] ? 6'd32 : 6'd24))
    else $error("address width does not follow enable");

  a_src_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(cs_n_reg) |-> ctrl_reg[sebl_pkg::CTRL_SRC])
    else $error("eeprom read while host is source");

  a_idle_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_reg == sebl_pkg::ST_IDLE) |-> (cs_n_reg && !sck_reg))
    else $error("serial bus active while idle");

  a_done_set: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(done_reg) |-> ($past(state_reg) == sebl_pkg::ST_TAIL) && cs_n_reg)
    else $error("done set outside end of frame");

  a_crc_result: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(cs_n_reg) |-> crc_err_reg == $past(crc_mis_w))
    else $error("crc status does not match check");

  a_bq_first: assert property (@(posedge hclk) disable iff (!hresetn)
    (coef_valid_reg && coef_first_reg) |-> ($past(bq_cnt_reg) == 5'h0) && (bq_cnt_reg == 5'h1))
    else $error("first coefficient mark misaligned");

endmodule

// ### verif/sebl_eeprom_model.sv
// Purpose: behavioural serial eeprom for the boot loader bench
// Assumes: bench configuration inputs stay steady over a frame
// Notes: a released data line shows the inverse of its last value
module sebl_eeprom_model (
  // serial link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  // bench configuration
  input wire logic pol,
  input wire logic lsb,
  input wire logic wide,
  input wire logic bad,
  input wire logic [7:0] base,
  // captured header bits
  output logic [31:0] hdr_raw
);
  timeunit 1ns;
  timeprecision 1ns;
  int s;
  int n;
  logic [15:0] crc;
  logic [7:0] d;

  function automatic logic [15:0] crc_of(input logic [7:0] b0);
    logic [15:0] c;
    c = 16'hffff;
    for (int j = 0; j < 40; j++) begin
      c = c ^ {8'(b0 + 8'(j)), 8'h00};
      for (int k = 0; k < 8; k++) begin
        c = c[15] ? ((c << 1) ^ 16'h1021) : (c << 1);
      end
    end
    return c;
  endfunction

  initial begin
    miso = 1'b0;
    s = 0;
    hdr_raw = '0;
  end
  always @(negedge cs_n) begin
    s = 0;
    hdr_raw = '0;
    crc = crc_of(base) ^ {15'h0, bad};
  end
  always @(posedge cs_n) miso = ~miso;
  always @(sck) begin
    n = s - (wide ? 32 : 24);
    if (!cs_n && sck == pol) begin
      if (n < 0) hdr_raw = {hdr_raw[30:0], mosi};
      s = s + 1;
    end else if (!cs_n && n >= 0) begin
      // keeps streaming while the clock runs
      d = (n / 8 < 40) ? base + 8'(n / 8) : ((n / 8 == 40) ? crc[15:8] : crc[7:0]);
      miso = lsb ? d[3'(n)] : d[~3'(n)];
    end
  end
endmodule

// ### verif/spi_eeprom_coef_boot_loader_tb.sv
// Purpose: self-checking bench for the coefficient boot loader
// Assumes: zero-wait AHB-Lite slave, eeprom model on the serial link
// Notes: each frame loads 40 bytes plus a crc pair
module spi_eeprom_coef_boot_loader_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, sck, cs_n, mosi, miso;
  logic [31:0] haddr, hwdata, hrdata, hdr_raw, rd;
  logic [1:0] htrans;
  logic coef_src_eeprom, coef_valid, coef_first, bq_flag, busy, irq;
  logic [7:0] coef_data, m_base;
  logic m_pol, m_lsb, m_wide, m_bad;
  int error_cnt, num_checks, idx, hi_len, last_hi;

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  sebl_boot_loader uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .coef_src_eeprom(coef_src_eeprom), .coef_data(coef_data), .coef_valid(coef_valid),
    .coef_first(coef_first), .biquad_first_coef_flag(bq_flag), .busy(busy), .irq(irq));
  sebl_eeprom_model eeprom (.sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso), .pol(m_pol), .lsb(m_lsb),
    .wide(m_wide), .bad(m_bad), .base(m_base), .hdr_raw(hdr_raw));

  // ----
  // shared tasks
  // ----
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task end_sim;
    if (error_cnt == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task ahb(input logic wr, input logic [7:0] ix, input logic [7:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {22'h0, ix, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    #1;
  endtask
  task rchk(input string name, input logic [7:0] ix, input logic [7:0] exp);
    ahb(1'b0, ix, 8'h00);
    chk(name, {24'h0, exp}, rd);
  endtask
  function automatic logic [7:0] rv(input logic [7:0] b, input logic l);
    return l ? {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]} : b;
  endfunction

  // ----
  // scenarios
  // ----
  task t_reset;
    logic [7:0] ix;
    for (int i = 0; i < 10; i++) begin
      ix = (i < 8) ? 8'h55 + 8'(i) : 8'h68 + 8'(i);
      rchk("reset value", ix, (ix == 8'h57) ? 8'h03 : 8'h00);
    end
    rchk("unmapped read", 8'h40, 8'h00);
    chk("idle select", 32'h1, {31'h0, cs_n});
    chk("okay response", 32'h0, {31'h0, hresp});
  endtask
  task t_regs;
    ahb(1'b1, 8'h55, 8'h0a);
    rchk("clock select", 8'h55, 8'h0a);
    ahb(1'b1, 8'h55, 8'h00);
    ahb(1'b1, 8'h5b, 8'hff);
    rchk("result read only", 8'h5b, 8'h00);
    ahb(1'b1, 8'h5c, 8'h01);
    rchk("biquad control", 8'h5c, 8'h01);
    chk("biquad flag", 32'h1, {31'h0, bq_flag});
    ahb(1'b1, 8'h5c, 8'h00);
    ahb(1'b1, 8'h40, 8'h5a);
    rchk("unmapped write", 8'h40, 8'h00);
    ahb(1'b1, 8'h56, 8'h3e);
    rchk("control", 8'h56, 8'h3e);
    chk("host source", 32'h0, {31'h0, coef_src_eeprom});
  endtask
  task t_frame(input logic [1:0] rate, input logic [1:0] csel, input logic pol, input logic lsb,
               input logic wide, input logic bad, input logic [7:0] op, input logic [7:0] hi,
               input logic [7:0] mid, input logic [7:0] lo);
    logic [1:0] er;
    logic [31:0] exp;
    er = (csel != 2'h0) ? csel : rate;
    exp = wide ? {rv(op, lsb), rv(hi, lsb), rv(mid, lsb), rv(lo, lsb)} : {8'h0, rv(op, lsb), rv(mid, lsb), rv(lo, lsb)};
    ahb(1'b1, 8'h57, op);
    ahb(1'b1, 8'h58, hi);
    ahb(1'b1, 8'h59, mid);
    ahb(1'b1, 8'h5a, lo);
    ahb(1'b1, 8'h55, {6'h0, csel});
    ahb(1'b1, 8'h71, 8'h03);
    ahb(1'b1, 8'h56, {2'h0, wide, rate, pol, lsb, 1'b0});
    m_pol <= pol;
    m_lsb <= lsb;
    m_wide <= wide;
    m_bad <= bad;
    m_base <= lo;
    idx = 0;
    ahb(1'b1, 8'h56, {2'h0, wide, rate, pol, lsb, 1'b1});
    chk("eeprom source", 32'h1, {31'h0, coef_src_eeprom});
    chk("busy", 32'h1, {31'h0, busy});
    for (int n = 0; n < 9000 && irq !== 1'b1; n++) @(posedge hclk);
    chk("done irq", 32'h1, {31'h0, irq});
    chk("header", exp, hdr_raw);
    chk("half period", 32'(8 >> er), 32'(last_hi));
    chk("byte count", 32'd40, 32'(idx));
    rchk("result", 8'h5b, {6'h0, bad, 1'b1});
    ahb(1'b1, 8'h71, 8'h00);
    chk("masked irq", 32'h0, {31'h0, irq});
    ahb(1'b1, 8'h71, 8'h03);
    rchk("irq status", 8'h70, {6'h0, bad, 1'b1});
    ahb(1'b1, 8'h70, 8'h03);
    chk("cleared irq", 32'h0, {31'h0, irq});
    chk("idle after frame", 32'h0, {31'h0, busy});
  endtask

  // ----
  // monitors and sequence
  // ----
  always @(posedge hclk) begin
    if (coef_valid === 1'b1) begin
      chk("coef data", {24'h0, m_base + 8'(idx)}, {24'h0, coef_data});
      chk("coef first", {31'h0, idx == 0 || idx == 20}, {31'h0, coef_first});
      idx++;
    end
    if (sck === 1'b1) hi_len++;
    else if (hi_len != 0) begin
      last_hi = hi_len;
      hi_len = 0;
    end
  end
  initial begin
    repeat (40000) @(posedge hclk);
    error_cnt++;
    end_sim;
  end
  initial begin
    {hresetn, hsel, hwrite, m_pol, m_lsb, m_wide, m_bad} = 7'h0;
    {haddr, hwdata, htrans, m_base} = '0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_regs;
    t_frame(2'h0, 2'h0, 1'b0, 1'b0, 1'b1, 1'b0, 8'h03, 8'h12, 8'h34, 8'h56);
    t_frame(2'h1, 2'h0, 1'b1, 1'b1, 1'b0, 1'b1, 8'h0b, 8'h9a, 8'hbc, 8'hde);
    t_frame(2'h2, 2'h0, 1'b0, 1'b1, 1'b1, 1'b0, 8'h5a, 8'h80, 8'h01, 8'hf0);
    t_frame(2'h3, 2'h0, 1'b1, 1'b0, 1'b0, 1'b0, 8'h6b, 8'h00, 8'h7f, 8'h10);
    t_frame(2'h1, 2'h2, 1'b1, 1'b0, 1'b1, 1'b1, 8'h03, 8'hff, 8'hee, 8'hdd);
    end_sim;
  end
endmodule
